// ### hdl/tdos_pkg.sv
package tdos_pkg;

    // ********************************
    // Sizes
    // ********************************
    localparam int PROG_CNT = 4;
    localparam int STEP_CNT = 16;
    localparam int PROG_W   = 2;
    localparam int STEP_W   = 4;
    localparam int DUR_W    = 22;
    localparam int CYC_W    = 10;

    localparam logic [DUR_W-1:0]  DUR_MAX   = 22'h36ee7f;  // 99:59:59.9 in tenths
    localparam logic [DUR_W-1:0]  DUR_ZERO  = 22'h000000;
    localparam logic [DUR_W-1:0]  DUR_ONE   = 22'h000001;
    localparam logic [CYC_W-1:0]  CYC_MAX   = 10'h3e7;     // 999
    localparam logic [CYC_W-1:0]  CYC_CONT  = 10'h000;     // Continuous
    localparam logic [CYC_W-1:0]  CYC_ONE   = 10'h001;
    localparam logic [STEP_W-1:0] STEP_FIRST = 4'h0;
    localparam logic [STEP_W-1:0] STEP_LAST  = 4'hf;
    localparam logic [STEP_W-1:0] STEP_ONE   = 4'h1;
    localparam int                STEP_KIND_BIT = 0;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS       = 100_000_000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 21;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        TDOS_ST_RESET,
        TDOS_ST_LOAD,
        TDOS_ST_TIME,
        TDOS_ST_END
    } tdos_state_t;

    typedef struct packed {
        logic              en;
        logic [PROG_W-1:0] prog;
        logic [STEP_W-1:0] step;
        logic [DUR_W-1:0]  dur;
    } tdos_wr_t;

    typedef struct packed {
        logic              output_on;
        logic              output_inv;
        logic              prog_end;
        logic              running;
        logic [PROG_W-1:0] active_prog;
        logic [STEP_W-1:0] step;
        logic [DUR_W-1:0]  time_rem;
        logic [CYC_W-1:0]  cycles_done;
    } tdos_stat_t;

endpackage

// ### hdl/tdos_seq.sv
`timescale 1ns/1ns
module tdos_seq #(
    parameter int TICK_CYCLES = tdos_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // Duration store write port
    input  wire tdos_pkg::tdos_wr_t            dur_wr,
    // Program choice
    input  wire logic [tdos_pkg::PROG_W-1:0]   program_count_limit,
    input  wire logic [tdos_pkg::PROG_W-1:0]   prog_select,
    input  wire logic [tdos_pkg::CYC_W-1:0]    program_cycles,
    // Run/hold and reset-release settings
    input  wire logic                          run_wr,
    input  wire logic                          run_val,
    input  wire logic                          release_wr,
    input  wire logic                          release_val,
    input  wire logic                          run_src_sel,
    input  wire logic                          run_src_level,
    input  wire logic                          release_src_sel,
    input  wire logic                          release_src_level,
    // Power restoration
    input  wire logic                          powerfail_hold_policy,
    input  wire logic                          power_restore,
    // Readback of the duration store
    input  wire logic [tdos_pkg::PROG_W-1:0]   rd_prog,
    input  wire logic [tdos_pkg::STEP_W-1:0]   rd_step,
    output logic      [tdos_pkg::DUR_W-1:0]    rd_dur,
    // Status
    output tdos_pkg::tdos_stat_t               status,
    output logic                               run_state,
    output logic                               release_state
);
    import tdos_pkg::*;

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [PROG_W-1:0] clamp_prog(
        input logic [PROG_W-1:0] sel,
        input logic [PROG_W-1:0] lim
    );
        clamp_prog = (sel > lim) ? lim : sel;
    endfunction

    // Even steps are On periods, odd steps Off periods
    function automatic logic step_is_on(input logic [STEP_W-1:0] s);
        step_is_on = ~s[STEP_KIND_BIT];
    endfunction

    function automatic logic [DUR_W-1:0] clamp_dur(input logic [DUR_W-1:0] d);
        clamp_dur = (d > DUR_MAX) ? DUR_MAX : d;
    endfunction

    function automatic logic [CYC_W-1:0] cap_cycles(input logic [CYC_W-1:0] c);
        cap_cycles = (c > CYC_MAX) ? CYC_MAX : c;
    endfunction

    // ********************************
    // Duration store
    // ********************************
    logic [DUR_W-1:0] dur_mem [PROG_CNT][STEP_CNT];
    logic [DUR_W-1:0] rd_dur_reg;

    // Programs default to all-zero durations, which leaves the output idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int p = 0; p < PROG_CNT; p++) begin
                for (int s = 0; s < STEP_CNT; s++) begin
                    dur_mem[p][s] <= DUR_ZERO;
                end
            end
        end else if (dur_wr.en) begin
            dur_mem[dur_wr.prog][dur_wr.step] <= clamp_dur(dur_wr.dur);
        end
    end

    // Readback is registered, so the word appears one clock after the address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_dur_reg <= DUR_ZERO;
        end else begin
            rd_dur_reg <= dur_mem[rd_prog][rd_step];
        end
    end

    assign rd_dur = rd_dur_reg;

    // ********************************
    // Run/hold and release settings
    // ********************************
    logic run_reg;
    logic run_next;
    logic release_reg;
    logic release_next;
    logic run_eff;
    logic release_eff;

    always_comb begin
        run_next     = run_reg;
        release_next = release_reg;
        if (run_wr) begin
            run_next = run_val;
        end
        if (release_wr) begin
            release_next = release_val;
        end
        // Restoration with the hold policy set outranks a same-cycle write so the plant comes up safe
        if (power_restore && powerfail_hold_policy) begin
            run_next     = 1'b0;
            release_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_reg     <= 1'b0;
            release_reg <= 1'b0;
        end else begin
            run_reg     <= run_next;
            release_reg <= release_next;
        end
    end

    // A wired source overrides the stored level, also after power restoration
    assign run_eff     = run_src_sel ? run_src_level : run_reg;
    assign release_eff = release_src_sel ? release_src_level : release_reg;

    // ********************************
    // Sequencer
    // ********************************
    tdos_state_t       state_reg;
    tdos_state_t       state_next;
    logic [STEP_W-1:0] step_reg;
    logic [STEP_W-1:0] step_next;
    logic [DUR_W-1:0]  rem_reg;
    logic [DUR_W-1:0]  rem_next;
    logic [TICK_W-1:0] tick_reg;
    logic [TICK_W-1:0] tick_next;
    logic [CYC_W-1:0]  cyc_reg;
    logic [CYC_W-1:0]  cyc_next;
    logic              out_reg;
    logic              out_next;
    logic [PROG_W-1:0] prog_reg;
    logic [PROG_W-1:0] prog_next;
    logic [PROG_W-1:0] prog_eff;
    logic [DUR_W-1:0]  cur_dur;
    logic              tick_wrap;
    logic [CYC_W-1:0]  cyc_inc;
    logic              seq_done;
    logic              pass_last;
    logic              load_zero;
    logic              running_reg;
    logic              running_next;

    assign prog_eff  = clamp_prog(prog_select, program_count_limit);
    assign cur_dur   = dur_mem[prog_reg][step_reg];
    assign pass_last = (step_reg == STEP_LAST);
    assign load_zero = (cur_dur == DUR_ZERO);
    // One tenth lasts TICK_CYCLES clocks; loading a period restarts the count
    assign tick_wrap = (tick_reg == TICK_W'(TICK_CYCLES - 1));
    // Continuous runs stop counting passes at 999 rather than rolling over to 0
    assign cyc_inc   = (cyc_reg == CYC_MAX) ? CYC_MAX : cyc_reg + CYC_ONE;
    // Counts above 999 are treated as 999
    assign seq_done  = (program_cycles != CYC_CONT) &&
                       (cyc_inc >= cap_cycles(program_cycles));

    always_comb begin
        state_next = state_reg;
        step_next  = step_reg;
        rem_next   = rem_reg;
        tick_next  = tick_reg;
        cyc_next   = cyc_reg;
        out_next   = out_reg;
        prog_next  = prog_reg;
        if (!release_eff) begin
            // Held in reset: nothing times, the pattern restarts from On 1
            state_next = TDOS_ST_RESET;
            step_next  = STEP_FIRST;
            rem_next   = DUR_ZERO;
            tick_next  = '0;
            cyc_next   = CYC_CONT;
            out_next   = 1'b0;
            prog_next  = prog_eff;
        end else begin
            case (state_reg)
                TDOS_ST_RESET: begin
                    prog_next = prog_eff;
                    // Starts standalone, no other programmer involved
                    if (run_eff) begin
                        state_next = TDOS_ST_LOAD;
                        step_next  = STEP_FIRST;
                    end
                end
                TDOS_ST_LOAD: begin
                    if (run_eff) begin
                        if (load_zero) begin
                            // Zero step: move on and keep the output as it is
                            step_next = step_reg + STEP_ONE;
                            if (pass_last) begin
                                cyc_next  = cyc_inc;
                                prog_next = prog_eff;
                                if (seq_done) begin
                                    state_next = TDOS_ST_END;
                                    out_next   = 1'b0;
                                end
                            end
                        end else begin
                            rem_next   = cur_dur;
                            tick_next  = '0;
                            out_next   = step_is_on(step_reg);
                            state_next = TDOS_ST_TIME;
                        end
                    end
                end
                TDOS_ST_TIME: begin
                    // Hold freezes the tick and remaining time, output kept
                    if (run_eff) begin
                        if (tick_wrap) begin
                            tick_next = '0;
                            if (rem_reg == DUR_ONE) begin
                                rem_next  = DUR_ZERO;
                                step_next = step_reg + STEP_ONE;
                                if (pass_last) begin
                                    cyc_next  = cyc_inc;
                                    prog_next = prog_eff;
                                    if (seq_done) begin
                                        state_next = TDOS_ST_END;
                                        out_next   = 1'b0;
                                    end else begin
                                        state_next = TDOS_ST_LOAD;
                                    end
                                end else begin
                                    state_next = TDOS_ST_LOAD;
                                end
                            end else begin
                                rem_next = rem_reg - DUR_ONE;
                            end
                        end else begin
                            tick_next = tick_reg + TICK_W'(1);
                        end
                    end
                end
                TDOS_ST_END: begin
                    // Leaves only through reset-release going off
                    out_next = 1'b0;
                end
                default: begin
                    state_next = TDOS_ST_RESET;
                end
            endcase
        end
        running_next = run_eff && release_eff && (state_next != TDOS_ST_END);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= TDOS_ST_RESET;
            step_reg  <= STEP_FIRST;
            rem_reg   <= DUR_ZERO;
            tick_reg  <= '0;
            cyc_reg   <= CYC_CONT;
            out_reg   <= 1'b0;
            prog_reg  <= '0;
            running_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            step_reg  <= step_next;
            rem_reg   <= rem_next;
            tick_reg  <= tick_next;
            cyc_reg   <= cyc_next;
            out_reg   <= out_next;
            prog_reg  <= prog_next;
            running_reg <= running_next;
        end
    end

    // ********************************
    // Status
    // ********************************
    always_comb begin
        status.output_on   = out_reg;
        status.output_inv  = ~out_reg;
        status.prog_end    = (state_reg == TDOS_ST_END);
        // Registered like the other status bits, so it trails the run level by a clock
        status.running     = running_reg;
        status.active_prog = prog_reg;
        status.step        = step_reg;
        status.time_rem    = rem_reg;
        status.cycles_done = cyc_reg;
    end

    assign run_state     = run_reg;
    assign release_state = release_reg;

endmodule

// ### tb/tdos_seq_properties.sv
`timescale 1ns/1ns
module tdos_seq_props (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    // Settings
    input wire logic                 run_wr,
    input wire logic                 run_val,
    input wire logic                 run_src_sel,
    input wire logic                 run_src_level,
    input wire logic                 release_src_sel,
    input wire logic                 release_src_level,
    input wire logic                 powerfail_hold_policy,
    input wire logic                 power_restore,
    // Status
    input wire tdos_pkg::tdos_stat_t status,
    input wire logic                 run_state,
    input wire logic                 release_state
);
    import tdos_pkg::*;
    // ****************
    // Effective levels
    // ****************
    logic run_eff;
    logic rel_eff;
    logic pf;
    assign run_eff = run_src_sel ? run_src_level : run_state;
    assign rel_eff = release_src_sel ? release_src_level : release_state;
    assign pf      = power_restore && powerfail_hold_policy;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_inv; status.output_inv == ~status.output_on; endproperty
    a_inv: assert property (p_inv) else $error("inverted output wrong");
    property p_run; status.running == ($past(run_eff && rel_eff && !sys_rst)
        && !status.prog_end); endproperty
    a_run: assert property (p_run) else $error("running level wrong");
    property p_wr; run_wr && !pf |=> run_state == $past(run_val); endproperty
    a_wr: assert property (p_wr) else $error("run write lost");
    property p_pf; pf |=> !run_state && !release_state; endproperty
    a_pf: assert property (p_pf) else $error("power restore state wrong");
    property p_rst; !rel_eff |=> status.step == STEP_FIRST && !status.output_on
        && status.cycles_done == CYC_CONT; endproperty
    a_rst: assert property (p_rst) else $error("not held in reset");
    property p_hold; !run_eff && rel_eff |=> $stable(status.time_rem)
        && $stable(status.step) && $stable(status.output_on); endproperty
    a_hold: assert property (p_hold) else $error("hold did not freeze");
    property p_rise; $rose(status.output_on) |-> !status.step[0]; endproperty
    a_rise: assert property (p_rise) else $error("output rose on off step");
    property p_end; status.prog_end |-> !status.output_on; endproperty
    a_end: assert property (p_end) else $error("output high at end");
    // Only plain countdown steps are judged; loads and resets pass through zero
    property p_dec; $past(status.time_rem) != DUR_ZERO && status.time_rem != DUR_ZERO
        && $changed(status.time_rem) |-> status.time_rem == $past(status.time_rem) - DUR_ONE;
    endproperty
    a_dec: assert property (p_dec) else $error("time step not one tenth");
endmodule
bind tdos_seq tdos_seq_props u_props (.*);

// ### tb/tdos_seq_tb.sv
`timescale 1ns/1ns
module tdos_seq_tb;
    import tdos_pkg::*;
    // ****************
    // Bench
    // ****************
    localparam int TK = 2;
    localparam int LIM = 400;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    tdos_wr_t          dur_wr = '0;
    logic [PROG_W-1:0] program_count_limit = 2'h3;
    logic [PROG_W-1:0] prog_select = 2'h0;
    logic [CYC_W-1:0]  program_cycles = 10'h002;
    logic              run_wr = 1'b0;
    logic              run_val = 1'b0;
    logic              release_wr = 1'b0;
    logic              release_val = 1'b0;
    logic              run_src_sel = 1'b0;
    logic              run_src_level;
    logic              release_src_sel = 1'b0;
    logic              release_src_level = 1'b0;
    logic              powerfail_hold_policy = 1'b0;
    logic              power_restore = 1'b0;
    logic [PROG_W-1:0] rd_prog = 2'h0;
    logic [STEP_W-1:0] rd_step = 4'h0;
    logic [DUR_W-1:0]  rd_dur;
    tdos_stat_t        status;
    logic              run_state;
    logic              release_state;
    logic              src_req = 1'b0;
    logic              low;
    logic [DUR_W-1:0]  tr;
    int                failures = 0;
    int                check_count = 0;
    int                n;
    tdos_seq #(.TICK_CYCLES(TK)) DUT (.*);
    tdos_src_model u_src (.clk(clk), .req(src_req), .slow(1'b1), .level(run_src_level));
    always #25 clk = ~clk;
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic lim(input int k);
        if (k >= LIM) begin
            failures++;
            test_done();
        end
    endtask
    // Leaves one idle edge so back-to-back calls never touch en twice at once
    task automatic put(input logic [1:0] p, input logic [3:0] s, input logic [21:0] d);
        dur_wr = '{1'b1, p, s, d};
        tick(1);
        dur_wr.en = 1'b0;
        tick(1);
    endtask
    task automatic get(input logic [1:0] p, input logic [3:0] s, input logic [21:0] e);
        rd_prog = p;
        rd_step = s;
        tick(2);
        chk(rd_dur, e);
    endtask
    task automatic cfg(input logic r, input logic v);
        run_wr = r;
        release_wr = !r;
        run_val = v;
        release_val = v;
        tick(1);
        run_wr = 1'b0;
        release_wr = 1'b0;
        tick(1);
    endtask
    task automatic prst(input logic pol);
        powerfail_hold_policy = pol;
        power_restore = 1'b1;
        tick(1);
        power_restore = 1'b0;
        tick(1);
    endtask
    initial begin
        tick(8);
        sys_rst = 1'b0;
        tick(1);
        chk(status.output_on, 1'b0);
        chk(status.output_inv, 1'b1);
        get(2'h0, 4'h0, DUR_ZERO);
        $display("test reset done");
        put(2'h1, 4'h3, 22'h3fffff);
        put(2'h0, 4'h0, 22'h000002);
        put(2'h0, 4'h2, DUR_ONE);
        put(2'h0, 4'h3, DUR_ONE);
        put(2'h1, 4'h0, 22'h000005);
        put(2'h2, 4'h0, 22'h000010);
        get(2'h1, 4'h3, DUR_MAX);
        get(2'h0, 4'h3, DUR_ONE);
        $display("test store done");
        cfg(1'b0, 1'b1);
        cfg(1'b1, 1'b1);
        for (n = 0; n < LIM && status.time_rem === DUR_ZERO; n++) tick(1);
        lim(n);
        chk(status.output_on, 1'b1);
        chk(status.step, STEP_FIRST);
        for (n = 0; n < LIM && status.step === STEP_FIRST; n++) tick(1);
        lim(n);
        chk(n, 2 * TK);
        low = 1'b0;
        for (n = 0; n < LIM && !(status.step === 4'h2 && status.time_rem !== 0); n++) begin
            low = low | ~status.output_on;
            tick(1);
        end
        lim(n);
        chk(low, 1'b0);
        chk(status.output_on, 1'b1);
        for (n = 0; n < LIM && !(status.step === 4'h3 && status.time_rem !== 0); n++) tick(1);
        lim(n);
        chk(status.output_on, 1'b0);
        for (n = 0; n < LIM && !(status.step === 4'h0 && status.time_rem !== 0); n++) tick(1);
        lim(n);
        chk(status.cycles_done, CYC_ONE);
        chk(status.output_on, 1'b1);
        for (n = 0; n < LIM && status.prog_end !== 1'b1; n++) tick(1);
        lim(n);
        chk(status.cycles_done, 10'h002);
        $display("test sequence done");
        cfg(1'b0, 1'b0);
        program_cycles = CYC_CONT;
        prog_select = 2'h2;
        cfg(1'b0, 1'b1);
        for (n = 0; n < LIM && status.time_rem === DUR_ZERO; n++) tick(1);
        lim(n);
        cfg(1'b1, 1'b0);
        tr = status.time_rem;
        tick(6);
        chk(status.time_rem, tr);
        chk(status.output_on, 1'b1);
        cfg(1'b1, 1'b1);
        tick(2 * TK + 1);
        chk(status.time_rem !== tr, 1'b1);
        $display("test hold done");
        run_src_sel = 1'b1;
        tick(3);
        chk(status.running, 1'b0);
        src_req = 1'b1;
        tick(3);
        chk(status.running, 1'b1);
        run_src_sel = 1'b0;
        release_src_sel = 1'b1;
        tick(2);
        chk(status.output_on, 1'b0);
        chk(status.time_rem, DUR_ZERO);
        chk(release_state, 1'b1);
        release_src_sel = 1'b0;
        $display("test wired source done");
        prog_select = 2'h3;
        program_count_limit = 2'h1;
        cfg(1'b0, 1'b0);
        cfg(1'b0, 1'b1);
        for (n = 0; n < LIM && status.time_rem === DUR_ZERO; n++) tick(1);
        lim(n);
        chk(status.active_prog, 2'h1);
        chk(status.time_rem, 22'h000005);
        $display("test limit done");
        prst(1'b0);
        chk(run_state, 1'b1);
        prst(1'b1);
        chk(run_state, 1'b0);
        chk(release_state, 1'b0);
        $display("test power restore done");
        test_done();
    end
endmodule

// ### tb/tdos_src_model.sv
`timescale 1ns/1ns
module tdos_src_model (
    // Clock
    input wire logic clk,
    // Wanted level and pace
    input wire logic req,
    input wire logic slow,
    // Run or hold level to the sequencer
    output logic     level
);
    // ****************
    // Wired source, a clock late, or two clocks with slow, like a debounced push-button
    // ****************
    logic req_dly = 1'b0;
    initial level = 1'b0;
    always @(posedge clk) begin
        req_dly <= req;
        level   <= slow ? req_dly : req;
    end
endmodule
